// File: dram_sig_regs.svh
// Purpose: Named constants for the DRAM strobe and refresh signalling block.
// Assumes: 20 MHz system clock.
// Notes: Times are in nanoseconds; refresh cycle counts derive from them.
`ifndef DRAM_SIG_REGS_SVH
`define DRAM_SIG_REGS_SVH
`define CLK_PERIOD_NS 50
`define REFRESH_SHORT_NS 13000
`define REFRESH_LONG_NS 15000
`define REFRESH_SHORT_CYC (`REFRESH_SHORT_NS / `CLK_PERIOD_NS)
`define REFRESH_LONG_CYC (`REFRESH_LONG_NS / `CLK_PERIOD_NS)
`define CFG_INTERVAL_BIT 0
`define CFG_PIPELINE_BIT 1
`define CFG_WIDTH 2
`define RAS_CYC 2
`endif

// File: dram_sig_pkg.sv
// Purpose: Types for the DRAM strobe and refresh signalling block.
// Assumes: Nothing.
// Notes: Sequencer states only.
package dram_sig_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_row,
    st_col,
    st_rf_arm,
    st_rf_ras,
    st_rf_end
  } seq_state_t;
endpackage : dram_sig_pkg

// File: refresh_timer.sv
// Purpose: Refresh interval counter raising a refresh-due level.
// Assumes: Interval select fixed while running.
// Notes: Due stays set until the refresh starts.
`timescale 1ns/1ns
`include "dram_sig_regs.svh"
module refresh_timer #(
  parameter int SHORT_CYC = `REFRESH_SHORT_CYC,
  parameter int LONG_CYC = `REFRESH_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic long_sel_i,
  input wire logic started_i,
  output logic due_o
);
  logic [15:0] count;

  initial begin
    if (SHORT_CYC < 2 || LONG_CYC < 2 || LONG_CYC > 65535) begin
      $error("refresh_timer: interval out of range");
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 16'h0000;
      due_o <= 1'b0;
    end else if (started_i) begin
      count <= 16'h0000;
      due_o <= 1'b0;
    end else if (!due_o) begin
      if (count == (long_sel_i ? 16'(LONG_CYC - 1) : 16'(SHORT_CYC - 1))) begin
        due_o <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule : refresh_timer

// File: dram_sig.sv
// Purpose: DRAM address multiplexing, strobes, write strobe and refresh.
// Assumes: Control pin inputs are asynchronous and synchronised here; address and bank inputs are used directly.
// Notes: Strobe outputs are active low, as on the DRAM.
`timescale 1ns/1ns
`include "dram_sig_regs.svh"
module dram_sig #(
  parameter int AW = 11
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic programming_load_strobe_n_i,
  input wire logic [AW-1:0] row_address_in_i,
  input wire logic [AW-1:0] column_address_in_i,
  input wire logic [1:0] bank_select_in_i,
  input wire logic byte_lane0_strobe_enable_n_i,
  input wire logic write_request_in_n_i,
  input wire logic access_request_i,
  input wire logic internal_refresh_inhibit_n_i,
  input wire logic external_refresh_request_n_i,
  input wire logic refresh_stretch_in_n_i,
  output logic [AW-1:0] dram_mux_address_out_o,
  output logic [3:0] row_strobe_out_n_o,
  output logic [3:0] column_strobe_out_n_o,
  output logic write_strobe_n_o,
  output logic refresh_active_out_n_o,
  output logic [`CFG_WIDTH-1:0] config_o
);
  logic [6:0] s1;
  logic [6:0] s2;
  logic load_n;
  logic lane0_n;
  logic win_n;
  logic areq;
  logic inhibit_n;
  logic external_refresh_request_n;
  logic stretch_n;
  logic external_refresh_request_prev_n;
  logic [`CFG_WIDTH-1:0] cfg;
  logic lane0_at_load;
  logic [1:0] bank;
  logic [AW-1:0] rf_row;
  logic due;
  logic started;
  logic [1:0] tcnt;
  logic due_pin;
  dram_sig_pkg::seq_state_t state;

  initial begin
    if (AW < 4 || AW > 16) begin
      $error("dram_sig: address width out of range");
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= '1;
      s2 <= '1;
    end else begin
      s1 <= {programming_load_strobe_n_i, byte_lane0_strobe_enable_n_i,
             write_request_in_n_i, ~access_request_i,
             internal_refresh_inhibit_n_i, external_refresh_request_n_i,
             refresh_stretch_in_n_i};
      s2 <= s1;
    end
  end

  assign {load_n, lane0_n, win_n} = s2[6:4];
  assign areq = ~s2[3];
  assign {inhibit_n, external_refresh_request_n, stretch_n} = s2[2:0];

  // Configuration is captured while the load strobe stays low.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= 2'h0;
      lane0_at_load <= 1'b1;
      bank <= 2'h0;
    end else if (!load_n) begin
      cfg[`CFG_INTERVAL_BIT] <= row_address_in_i[`CFG_INTERVAL_BIT];
      cfg[`CFG_PIPELINE_BIT] <= column_address_in_i[`CFG_INTERVAL_BIT];
      lane0_at_load <= ~lane0_n;
      bank <= bank_select_in_i;
    end else if (state == dram_sig_pkg::st_idle) begin
      // The bank is taken while idle, so each access fires its own strobes.
      bank <= bank_select_in_i;
    end
  end

  refresh_timer u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .long_sel_i(cfg[`CFG_INTERVAL_BIT]),
    .started_i(started),
    .due_o(due)
  );

  assign started = (state == dram_sig_pkg::st_rf_arm);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      external_refresh_request_prev_n <= 1'b1;
    end else begin
      external_refresh_request_prev_n <= external_refresh_request_n;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_row <= '0;
    end else if (inhibit_n && !external_refresh_request_n && external_refresh_request_prev_n) begin
      rf_row <= '0;
    end else if (state == dram_sig_pkg::st_rf_end) begin
      rf_row <= rf_row + AW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= dram_sig_pkg::st_idle;
      tcnt <= 2'h0;
    end else begin
      case (state)
        dram_sig_pkg::st_idle: begin
          tcnt <= 2'h0;
          if ((inhibit_n && due) || (!inhibit_n && !external_refresh_request_n)) begin
            state <= dram_sig_pkg::st_rf_arm;
          end else if (areq && load_n) begin
            state <= dram_sig_pkg::st_row;
          end
        end
        dram_sig_pkg::st_row: state <= dram_sig_pkg::st_col;
        dram_sig_pkg::st_col: begin
          if (!areq) begin
            state <= dram_sig_pkg::st_idle;
          end
        end
        dram_sig_pkg::st_rf_arm: state <= dram_sig_pkg::st_rf_ras;
        dram_sig_pkg::st_rf_ras: begin
          if (tcnt != 2'(`RAS_CYC - 1)) begin
            tcnt <= tcnt + 2'h1;
          end else if (stretch_n) begin
            state <= dram_sig_pkg::st_rf_end;
          end
        end
        dram_sig_pkg::st_rf_end: state <= dram_sig_pkg::st_idle;
        default: state <= dram_sig_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dram_mux_address_out_o <= '0;
      row_strobe_out_n_o <= 4'hf;
      column_strobe_out_n_o <= 4'hf;
      refresh_active_out_n_o <= 1'b1;
    end else begin
      case (state)
        dram_sig_pkg::st_idle: begin
          dram_mux_address_out_o <= row_address_in_i;
          row_strobe_out_n_o <= 4'hf;
          column_strobe_out_n_o <= 4'hf;
          refresh_active_out_n_o <= 1'b1;
        end
        dram_sig_pkg::st_row: begin
          row_strobe_out_n_o <= ~(4'h1 << bank);
          dram_mux_address_out_o <= row_address_in_i;
        end
        dram_sig_pkg::st_col: begin
          dram_mux_address_out_o <= column_address_in_i;
          column_strobe_out_n_o <= (dram_mux_address_out_o ==
            column_address_in_i) ? ~(4'h1 << bank) : 4'hf;
        end
        dram_sig_pkg::st_rf_arm: begin
          refresh_active_out_n_o <= 1'b0;
          dram_mux_address_out_o <= rf_row;
        end
        dram_sig_pkg::st_rf_ras: begin
          row_strobe_out_n_o <= 4'h0;
          dram_mux_address_out_o <= rf_row;
        end
        dram_sig_pkg::st_rf_end: begin
          row_strobe_out_n_o <= 4'hf;
          dram_mux_address_out_o <= rf_row;
        end
        default: row_strobe_out_n_o <= 4'hf;
      endcase
    end
  end

  assign due_pin = cfg[`CFG_PIPELINE_BIT] || !lane0_at_load;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      write_strobe_n_o <= 1'b1;
      config_o <= 2'h0;
    end else begin
      config_o <= cfg;
      if (due_pin) begin
        write_strobe_n_o <= ~due;
      end else begin
        write_strobe_n_o <= win_n;
      end
    end
  end

  a_due_flag_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(due) && due_pin && $stable(due_pin) |=> !write_strobe_n_o)
    else $error("refresh-due not shown on shared pin");

  a_refresh_active_out_before_ras: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(row_strobe_out_n_o[0]) && refresh_active_out_n_o == 1'b0
    |-> $past(refresh_active_out_n_o) == 1'b0)
    else $error("row strobe fell with refresh-active");

  a_refresh_active_out_after_ras: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(refresh_active_out_n_o) |-> row_strobe_out_n_o == 4'hf)
    else $error("refresh-active negated with row strobe low");

  a_refresh_addr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !refresh_active_out_n_o && $past(state) == dram_sig_pkg::st_rf_ras
    |-> dram_mux_address_out_o == $past(rf_row))
    else $error("refresh row not on address outputs");

  a_refresh_ras: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == dram_sig_pkg::st_rf_arm |=> ##1 row_strobe_out_n_o == 4'h0)
    else $error("refresh row strobes not asserted");

  a_stretch_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == dram_sig_pkg::st_rf_ras && tcnt == 2'(`RAS_CYC - 1) && !stretch_n
    |=> state == dram_sig_pkg::st_rf_ras)
    else $error("refresh not stretched");

  a_col_after_row: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(column_strobe_out_n_o[bank]) |-> row_strobe_out_n_o[bank] == 1'b0
    && $past(row_strobe_out_n_o[bank]) == 1'b0)
    else $error("column strobe before row strobe");

  a_due_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    started |=> !due)
    else $error("refresh-due not cleared on start");

  a_auto_refresh: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == dram_sig_pkg::st_idle && due && inhibit_n
    |=> state == dram_sig_pkg::st_rf_arm)
    else $error("internal refresh not started");
endmodule : dram_sig

// File: dram_array_model.sv
// Purpose: DRAM bank model latching row, column and write level.
// Assumes: Strobes are active low and settle before the falling clock.
// Notes: Sampling on the falling clock avoids races with the strobes.
`timescale 1ns/1ns
module dram_array_model #(
  parameter int AW = 11
) (
  input wire logic clk_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [3:0] ras_n_i,
  input wire logic [3:0] cas_n_i,
  input wire logic we_n_i,
  output logic [AW-1:0] row_o,
  output logic [AW-1:0] col_o,
  output logic [3:0] ras_seen_o,
  output logic we_o
);
  logic [3:0] ras_q = 4'hf;
  logic [3:0] cas_q = 4'hf;
  always @(negedge clk_i) begin
    if (ras_q == 4'hf && ras_n_i != 4'hf) begin
      row_o <= addr_i;
      ras_seen_o <= ras_n_i;
    end
    if (cas_q == 4'hf && cas_n_i != 4'hf) begin
      col_o <= addr_i;
      we_o <= we_n_i;
    end
    ras_q <= ras_n_i;
    cas_q <= cas_n_i;
  end
endmodule : dram_array_model

// File: testbench.sv
// Purpose: Self-checking bench for the DRAM signalling block.
// Assumes: Inputs change at the rising clock, outputs read at the falling.
// Notes: Refresh interval counts keep their full values.
`timescale 1ns/1ns
`include "dram_sig_regs.svh"
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ld_n = 1'b1;
  logic [10:0] ra = 11'h000;
  logic [10:0] ca = 11'h000;
  logic [1:0] ba = 2'h0;
  logic ln_n = 1'b0;
  logic wr_n = 1'b1;
  logic req = 1'b0;
  logic inh_n = 1'b0;
  logic ext_n = 1'b1;
  logic st_n = 1'b1;
  logic [10:0] q;
  logic [3:0] ras_n;
  logic [3:0] cas_n;
  logic ws_n;
  logic refresh_active_out_n;
  logic [1:0] cfg;
  logic [10:0] m_row;
  logic [10:0] m_col;
  logic [3:0] m_ras;
  logic m_we;
  logic [10:0] rrow = 11'h000;
  int num_errors = 0;
  int checks = 0;
  int n;
  int lim;
  dram_sig #(.AW(11)) dut_u (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .programming_load_strobe_n_i(ld_n),
    .row_address_in_i(ra),
    .column_address_in_i(ca),
    .bank_select_in_i(ba),
    .byte_lane0_strobe_enable_n_i(ln_n),
    .write_request_in_n_i(wr_n),
    .access_request_i(req),
    .internal_refresh_inhibit_n_i(inh_n),
    .external_refresh_request_n_i(ext_n),
    .refresh_stretch_in_n_i(st_n),
    .dram_mux_address_out_o(q),
    .row_strobe_out_n_o(ras_n),
    .column_strobe_out_n_o(cas_n),
    .write_strobe_n_o(ws_n),
    .refresh_active_out_n_o(refresh_active_out_n),
    .config_o(cfg)
  );
  dram_array_model #(.AW(11)) array_u (
    .clk_i(clk_i),
    .addr_i(q),
    .ras_n_i(ras_n),
    .cas_n_i(cas_n),
    .we_n_i(ws_n),
    .row_o(m_row),
    .col_o(m_col),
    .ras_seen_o(m_ras),
    .we_o(m_we)
  );
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc
  task prog(input logic iv, input logic pp, input logic l0);
    @(posedge clk_i);
    ld_n <= 1'b0;
    ra <= {10'h000, iv};
    ca <= {10'h000, pp};
    ln_n <= l0;
    cyc(4);
    @(posedge clk_i);
    ld_n <= 1'b1;
    cyc(4);
    chk(cfg, {pp, iv});
    $display("test program done");
  endtask : prog
  task acc(input logic [1:0] b, input logic w);
    @(posedge clk_i);
    ba <= b;
    ra <= 11'h555 ^ b;
    ca <= 11'h2aa ^ b;
    wr_n <= w;
    req <= 1'b1;
    for (n = 0; n < 10 && cas_n === 4'hf; n++) cyc(1);
    // One more cycle lets the array model settle what it latched.
    cyc(1);
    chk(m_row, 11'h555 ^ b);
    chk(m_ras, 4'(~(4'h1 << b)));
    chk(m_col, 11'h2aa ^ b);
    chk(cas_n, 4'(~(4'h1 << b)));
    chk(ws_n, w);
    chk(m_we, w);
    @(posedge clk_i);
    req <= 1'b0;
    cyc(5);
    chk(ras_n, 4'hf);
    $display("test access done");
  endtask : acc
  task rf(input logic ext, input logic st);
    @(posedge clk_i);
    ext_n <= ~ext;
    st_n <= ~st;
    for (n = 0; n < 400 && refresh_active_out_n !== 1'b0; n++) cyc(1);
    chk(ras_n, 4'hf);
    chk(q, rrow);
    @(posedge clk_i);
    ext_n <= 1'b1;
    for (n = 0; n < 3 && ras_n !== 4'h0; n++) cyc(1);
    chk(ras_n, 4'h0);
    for (n = 0; n < 20 && ras_n === 4'h0; n++) begin
      chk(refresh_active_out_n, 1'b0);
      @(posedge clk_i);
      if (n == 5) st_n <= 1'b1;
      @(negedge clk_i);
    end
    // A release in the sixth cycle reaches the sequencer three edges later.
    if (st) chk(n, 10);
    else chk(n, `RAS_CYC);
    chk(m_row, rrow);
    chk(m_ras, 4'h0);
    chk(refresh_active_out_n, 1'b0);
    cyc(1);
    chk(refresh_active_out_n, 1'b1);
    rrow++;
    $display("test refresh done");
  endtask : rf
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(2);
    prog(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) acc(i[1:0], i[0]);
    rf(1'b1, 1'b0);
    rf(1'b1, 1'b1);
    for (int i = 0; i < 2; i++) begin
      prog(i[0], i[0], ~i[0]);
      rf(1'b1, 1'b0);
      lim = i ? `REFRESH_LONG_CYC : `REFRESH_SHORT_CYC;
      for (n = 0; n < 400 && ws_n !== 1'b0; n++) cyc(1);
      chk(n > lim - 12 && n < lim + 2, 1'b1);
      cyc(20);
      chk(ws_n, 1'b0);
      rf(1'b1, 1'b0);
      chk(ws_n, 1'b1);
    end
    @(posedge clk_i);
    inh_n <= 1'b1;
    cyc(3);
    @(posedge clk_i);
    ext_n <= 1'b0;
    cyc(3);
    @(posedge clk_i);
    ext_n <= 1'b1;
    rrow = 11'h000;
    rf(1'b0, 1'b0);
    wrap_up();
  end
endmodule : testbench
